// ---- nfs_consts.svh ----
`ifndef NFS_CONSTS_SVH
`define NFS_CONSTS_SVH

// ***************************************************************
// Register map (byte addresses on APB)
// ***************************************************************
`define NFS_REG_CMD 8'h00
`define NFS_REG_ADDR 8'h04
`define NFS_REG_WDATA 8'h08
`define NFS_REG_RDATA 8'h0c
`define NFS_REG_STATUS 8'h10
`define NFS_REG_CFG 8'h14

// Status register bit positions
`define NFS_ST_BUSY 0
`define NFS_ST_DONE 1
`define NFS_ST_FAIL 2
`define NFS_ST_WIN 3
`define NFS_ST_REFUSED 4
`define NFS_ST_GUARD 5

// ***************************************************************
// Timing
// ***************************************************************
`define NFS_CLK_NS 50
`define NFS_WP_NS 100
`define NFS_WP_CYC ((`NFS_WP_NS + `NFS_CLK_NS - 1) / `NFS_CLK_NS)
`define NFS_RD_NS 300
`define NFS_RD_CYC ((`NFS_RD_NS + `NFS_CLK_NS - 1) / `NFS_CLK_NS)
`define NFS_SE_WIN_NS 80000
`define NFS_SE_MARGIN_NS 10000
`define NFS_SE_GUARD_CYC ((`NFS_SE_WIN_NS - `NFS_SE_MARGIN_NS) / `NFS_CLK_NS)

// ***************************************************************
// Flash command words and unlock addresses
// ***************************************************************
`define NFS_D_UNLOCK1 16'h00aa
`define NFS_D_UNLOCK2 16'h0055
`define NFS_D_RESET 16'h00f0
`define NFS_D_IDENT 16'h0090
`define NFS_D_PROGRAM 16'h00a0
`define NFS_D_ERASE 16'h0080
`define NFS_D_CHIP 16'h0010
`define NFS_D_SECTOR 16'h0030
`define NFS_A_U1_WORD 20'h00555
`define NFS_A_U2_WORD 20'h002aa
`define NFS_A_U1_BYTE 20'h00aaa
`define NFS_A_U2_BYTE 20'h00555
`define NFS_A_ZERO 20'h00000

// Data bit positions in the flash status word
`define NFS_POLL_BIT 7
`define NFS_TLIM_BIT 5
`define NFS_WIN_BIT 3

`endif

// ---- nfs_pkg.sv ----
package nfs_pkg;

    // ***************************************************************
    // Operations that software can launch
    // ***************************************************************
    typedef enum logic [2:0] {
        NFS_OP_RESET = 3'h0,
        NFS_OP_READ = 3'h1,
        NFS_OP_IDENT = 3'h2,
        NFS_OP_PROGRAM = 3'h3,
        NFS_OP_CHIP = 3'h4,
        NFS_OP_SECTOR = 3'h5,
        NFS_OP_ADD = 3'h6,
        NFS_OP_POLL = 3'h7
    } nfs_op_t;

    // Bus sequencer states, Gray along the order IDLE, WSET, WPUL, WEND, RPUL, REND
    typedef enum logic [2:0] {
        NFS_S_IDLE = 3'b000,
        NFS_S_WSET = 3'b001,
        NFS_S_WPUL = 3'b011,
        NFS_S_WEND = 3'b010,
        NFS_S_RPUL = 3'b110,
        NFS_S_REND = 3'b111
    } nfs_state_t;

endpackage : nfs_pkg

// ---- nfs_host.sv ----
// Behaviour
// - F0 at any address, or any bad sequence, returns flash to reads.
// - Commands open with AA to 555 then 55 to 2AA (byte: AAA, 555).
// - Codes: 90 identify, A0 program, 80 erase; then 10 chip, 30 sector.
// - Identify mode lasts until the reset command is written.
// - Program is four writes: two unlocks, setup, address with data.
// - Chip erase is six writes: unlocks, 80, unlocks, 10.
// - Each further sector command adds a sector and restarts the timer.
// - Sector erase touches selected sectors; poll inside an erasing one.
// - Queue sector commands without long stalls between writes.
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "nfs_consts.svh"

module nfs_host (
    input wire logic clk, // 20 MHz clock
    input wire logic reset, // Synchronous, active high
    input wire logic [7:0] paddr, // APB address
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    output logic [19:0] fl_addr, // Flash address
    output logic fl_ce_n, // Flash chip select
    output logic fl_we_n, // Flash write strobe
    output logic fl_oe_n, // Flash output strobe
    output logic [15:0] fl_dq_out, // Flash data driven by us
    output logic fl_dq_oe_n, // Low while we drive the data pins
    input wire logic [15:0] fl_dq_in // Flash data pins as seen
);
    import nfs_pkg::*;

    // ***************************************************************
    // Pin input synchroniser
    // ***************************************************************
    logic [15:0] dq_s1, dq_s2, dq_s3, dq_q;
    logic [15:0] next_dq_q;

    // Accept a new value only once two late stages agree
    always_comb begin
        next_dq_q = (dq_s2 == dq_s3) ? dq_s3 : dq_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dq_s1 <= 16'h0000;
            dq_s2 <= 16'h0000;
            dq_s3 <= 16'h0000;
            dq_q <= 16'h0000;
        end else begin
            dq_s1 <= fl_dq_in;
            dq_s2 <= dq_s1;
            dq_s3 <= dq_s2;
            dq_q <= next_dq_q;
        end
    end

    // ***************************************************************
    // APB slave and software registers
    // ***************************************************************
    logic [19:0] addr_reg, next_addr_reg;
    logic [15:0] wdata_reg, next_wdata_reg;
    logic byte_mode, next_byte_mode;
    logic [2:0] cmd_reg, next_cmd_reg;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic wr_fire, cmd_wr, start;
    logic [15:0] rdata;
    logic busy, done, fail, win_flag, refused, guard_open;

    // A write commits where the master sees pready high
    assign wr_fire = psel & penable & pready & pwrite;
    assign cmd_wr = wr_fire && (paddr == `NFS_REG_CMD);
    assign start = cmd_wr && !busy;

    always_comb begin
        next_addr_reg = addr_reg;
        next_wdata_reg = wdata_reg;
        next_byte_mode = byte_mode;
        next_cmd_reg = cmd_reg;
        next_pready = psel & penable & ~pready;
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (wr_fire) begin
            unique case (paddr)
                `NFS_REG_ADDR: next_addr_reg = pwdata[19:0];
                `NFS_REG_WDATA: next_wdata_reg = pwdata[15:0];
                `NFS_REG_CFG: next_byte_mode = pwdata[0];
                `NFS_REG_CMD: if (!busy) next_cmd_reg = pwdata[2:0];
                default: ;
            endcase
        end
        // Read data and error register in the same cycle as pready
        if (psel & penable & ~pready) begin
            unique case (paddr)
                `NFS_REG_CMD: next_prdata = {29'h0, cmd_reg};
                `NFS_REG_ADDR: next_prdata = {12'h000, addr_reg};
                `NFS_REG_WDATA: next_prdata = {16'h0000, wdata_reg};
                `NFS_REG_RDATA: next_prdata = {16'h0000, rdata};
                `NFS_REG_STATUS: next_prdata = {26'h0, guard_open,
                    refused, win_flag, fail, done, busy};
                `NFS_REG_CFG: next_prdata = {31'h0, byte_mode};
                default: next_pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            addr_reg <= 20'h00000;
            wdata_reg <= 16'hffff;
            byte_mode <= 1'b0;
            cmd_reg <= 3'h0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            addr_reg <= next_addr_reg;
            wdata_reg <= next_wdata_reg;
            byte_mode <= next_byte_mode;
            cmd_reg <= next_cmd_reg;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ***************************************************************
    // Command script: address and data of each write step
    // ***************************************************************
    function automatic logic [35:0] step_word(input nfs_op_t op,
            input logic [2:0] k, input logic bm,
            input logic [19:0] a, input logic [15:0] d);
        logic [19:0] u1, u2;
        u1 = bm ? `NFS_A_U1_BYTE : `NFS_A_U1_WORD;
        u2 = bm ? `NFS_A_U2_BYTE : `NFS_A_U2_WORD;
        step_word = {u1, `NFS_D_UNLOCK1};
        if (op == NFS_OP_RESET) begin
            step_word = {`NFS_A_ZERO, `NFS_D_RESET};
        end else if (op == NFS_OP_ADD) begin
            step_word = {a, `NFS_D_SECTOR};
        end else begin
            unique case (k)
                3'd1, 3'd4: step_word = {u2, `NFS_D_UNLOCK2};
                3'd2: begin
                    unique case (op)
                        NFS_OP_IDENT: step_word = {u1, `NFS_D_IDENT};
                        NFS_OP_PROGRAM: step_word = {u1, `NFS_D_PROGRAM};
                        default: step_word = {u1, `NFS_D_ERASE};
                    endcase
                end
                3'd3: begin
                    if (op == NFS_OP_PROGRAM)
                        step_word = {a, d};
                    else
                        step_word = {u1, `NFS_D_UNLOCK1};
                end
                3'd5: begin
                    if (op == NFS_OP_CHIP)
                        step_word = {u1, `NFS_D_CHIP};
                    else
                        step_word = {a, `NFS_D_SECTOR};
                end
                default: step_word = {u1, `NFS_D_UNLOCK1};
            endcase
        end
    endfunction : step_word

    // Number of write cycles each operation issues
    function automatic logic [2:0] n_writes(input nfs_op_t op);
        unique case (op)
            NFS_OP_RESET, NFS_OP_ADD: n_writes = 3'd1;
            NFS_OP_READ, NFS_OP_POLL: n_writes = 3'd0;
            NFS_OP_IDENT: n_writes = 3'd3;
            NFS_OP_PROGRAM: n_writes = 3'd4;
            default: n_writes = 3'd6;
        endcase
    endfunction : n_writes

    // ***************************************************************
    // Flash bus sequencer
    // ***************************************************************
    nfs_state_t state, next_state;
    nfs_op_t op, next_op;
    logic [2:0] step, next_step;
    logic [3:0] cnt, next_cnt;
    logic [11:0] guard, next_guard;
    logic retry, next_retry;
    logic next_busy, next_done, next_fail, next_win_flag, next_refused;
    logic [15:0] next_rdata;
    logic [19:0] next_fl_addr;
    logic [15:0] next_fl_dq_out;
    logic next_ce_n, next_we_n, next_oe_n, next_dq_oe_n;
    logic [35:0] word;
    logic ok;

    assign guard_open = (guard != 12'h000);

    always_comb begin
        next_state = state;
        next_op = op;
        next_step = step;
        next_cnt = cnt;
        next_guard = guard_open ? guard - 12'h001 : guard;
        next_retry = retry;
        next_busy = busy;
        next_done = done;
        next_fail = fail;
        next_win_flag = win_flag;
        next_refused = refused;
        next_rdata = rdata;
        next_fl_addr = fl_addr;
        next_fl_dq_out = fl_dq_out;
        next_ce_n = fl_ce_n;
        next_we_n = fl_we_n;
        next_oe_n = fl_oe_n;
        next_dq_oe_n = fl_dq_oe_n;
        word = step_word(op, step + 3'd1, byte_mode, addr_reg, wdata_reg);
        ok = 1'b0;
        // A refused command is flagged; a launch clears done, fail and refused
        if (cmd_wr && busy)
            next_refused = 1'b1;
        unique case (state)
            NFS_S_IDLE: begin
                if (start) begin
                    next_op = nfs_op_t'(pwdata[2:0]);
                    next_step = 3'd0;
                    next_retry = 1'b0;
                    next_done = 1'b0;
                    next_fail = 1'b0;
                    next_refused = 1'b0;
                    if (nfs_op_t'(pwdata[2:0]) == NFS_OP_ADD &&
                            !guard_open) begin
                        // Too late to append: the flash may start erasing first
                        next_refused = 1'b1;
                    end else begin
                        // Anything but an append ends the window
                        if (nfs_op_t'(pwdata[2:0]) != NFS_OP_ADD)
                            next_guard = 12'h000;
                        next_busy = 1'b1;
                        word = step_word(nfs_op_t'(pwdata[2:0]), 3'd0,
                            byte_mode, addr_reg, wdata_reg);
                        if (n_writes(nfs_op_t'(pwdata[2:0])) == 3'd0) begin
                            next_fl_addr = addr_reg;
                            next_ce_n = 1'b0;
                            next_oe_n = 1'b0;
                            next_cnt = 4'(`NFS_RD_CYC);
                            next_state = NFS_S_RPUL;
                        end else begin
                            next_fl_addr = word[35:16];
                            next_fl_dq_out = word[15:0];
                            next_dq_oe_n = 1'b0;
                            next_state = NFS_S_WSET;
                        end
                    end
                end
            end
            NFS_S_WSET: begin
                // Address set early, stable at the fall
                next_ce_n = 1'b0;
                next_we_n = 1'b0;
                next_cnt = 4'(`NFS_WP_CYC);
                next_state = NFS_S_WPUL;
            end
            NFS_S_WPUL: begin
                next_cnt = cnt - 4'd1;
                if (cnt == 4'd1) begin
                    // Both strobes rise together; data still driven
                    next_ce_n = 1'b1;
                    next_we_n = 1'b1;
                    next_state = NFS_S_WEND;
                    if ((op == NFS_OP_SECTOR || op == NFS_OP_ADD) &&
                            step == n_writes(op) - 3'd1)
                        next_guard = 12'(`NFS_SE_GUARD_CYC);
                end
            end
            NFS_S_WEND: begin
                next_dq_oe_n = 1'b1;
                next_step = step + 3'd1;
                if (step + 3'd1 < n_writes(op)) begin
                    next_fl_addr = word[35:16];
                    next_fl_dq_out = word[15:0];
                    next_dq_oe_n = 1'b0;
                    next_state = NFS_S_WSET;
                end else if (op == NFS_OP_PROGRAM || op == NFS_OP_CHIP) begin
                    // Poll at the target; chip erase accepts any address
                    next_fl_addr = addr_reg;
                    next_ce_n = 1'b0;
                    next_oe_n = 1'b0;
                    next_cnt = 4'(`NFS_RD_CYC);
                    next_state = NFS_S_RPUL;
                end else begin
                    next_busy = 1'b0;
                    next_done = 1'b1;
                    next_state = NFS_S_IDLE;
                end
            end
            NFS_S_RPUL: begin
                next_cnt = cnt - 4'd1;
                if (cnt == 4'd1) begin
                    // Read time covers access plus synchroniser delay
                    next_rdata = dq_q;
                    next_win_flag = dq_q[`NFS_WIN_BIT];
                    next_ce_n = 1'b1;
                    next_oe_n = 1'b1;
                    next_state = NFS_S_REND;
                end
            end
            NFS_S_REND: begin
                // Program compares bit 7 with the value written
                if (op == NFS_OP_PROGRAM)
                    ok = (rdata[`NFS_POLL_BIT] ==
                        wdata_reg[`NFS_POLL_BIT]);
                else
                    ok = rdata[`NFS_POLL_BIT];
                if (op == NFS_OP_READ || ok) begin
                    next_busy = 1'b0;
                    next_done = 1'b1;
                    next_state = NFS_S_IDLE;
                end else if (retry) begin
                    // Time flag up and reread still fails
                    next_busy = 1'b0;
                    next_fail = 1'b1;
                    next_state = NFS_S_IDLE;
                end else begin
                    if (rdata[`NFS_TLIM_BIT])
                        next_retry = 1'b1;
                    next_ce_n = 1'b0;
                    next_oe_n = 1'b0;
                    next_cnt = 4'(`NFS_RD_CYC);
                    next_state = NFS_S_RPUL;
                end
            end
            default: begin
                next_state = NFS_S_IDLE;
                next_busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= NFS_S_IDLE;
            op <= NFS_OP_RESET;
            step <= 3'd0;
            cnt <= 4'd0;
            guard <= 12'h000;
            retry <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            fail <= 1'b0;
            win_flag <= 1'b0;
            refused <= 1'b0;
            rdata <= 16'h0000;
            fl_addr <= 20'h00000;
            fl_dq_out <= 16'h0000;
            fl_ce_n <= 1'b1;
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
            fl_dq_oe_n <= 1'b1;
        end else begin
            state <= next_state;
            op <= next_op;
            step <= next_step;
            cnt <= next_cnt;
            guard <= next_guard;
            retry <= next_retry;
            busy <= next_busy;
            done <= next_done;
            fail <= next_fail;
            win_flag <= next_win_flag;
            refused <= next_refused;
            rdata <= next_rdata;
            fl_addr <= next_fl_addr;
            fl_dq_out <= next_fl_dq_out;
            fl_ce_n <= next_ce_n;
            fl_we_n <= next_we_n;
            fl_oe_n <= next_oe_n;
            fl_dq_oe_n <= next_dq_oe_n;
        end
    end

endmodule : nfs_host

// ---- nfs_flash.sv ----
`timescale 1ns/1ps
// ****
// Flash device model, strobe driven
// ****
module nfs_flash #(
    parameter logic [15:0] MAKER = 16'h0007, // Arbitrary value
    parameter logic [15:0] DEV = 16'h0380, // Arbitrary value
    parameter logic [127:0] PROT = 128'h20 // Sector 5 protected
) (
    input wire logic [19:0] addr, // Address pins
    input wire logic ce_n, // Chip select
    input wire logic we_n, // Write strobe
    input wire logic oe_n, // Output strobe
    input wire logic [15:0] din, // Resolved data wire
    output logic [15:0] dout, // Data to drive
    output logic drive // High while driving
);
    logic [15:0] mem [int];
    time mt [int];
    time et [128];
    logic [127:0] sel;
    logic [19:0] la;
    logic [15:0] pd;
    logic [2:0] step;
    logic armed, ident, busy, swin, ers;
    time t_last, t_end;
    initial begin
        foreach (et[s]) et[s] = 0;
        {sel, step, armed, ident, busy, swin, ers, pd} = '0;
    end
    // Erase stamps a sector instead of walking the array
    function automatic logic [15:0] rd(input int a);
        return mem.exists(a) && mt[a] > et[a[18:12]] ? mem[a] : 16'hffff;
    endfunction : rd
    task automatic wr(input logic [19:0] a, input logic [15:0] d);
        logic u1, u2;
        u1 = a[10:0] == 11'h555 || a[10:0] == 11'haaa;
        u2 = a[10:0] == 11'h2aa || a[10:0] == 11'h555;
        if (busy) return;
        if (swin) begin
            if (d[7:0] == 8'h30) begin
                sel[a[18:12]] = 1'b1;
                t_last = $time;
            end else begin
                swin = 1'b0;
                sel = '0;
                step = 3'h0;
            end
            return;
        end
        if (d[7:0] == 8'hf0) begin
            ident = 1'b0;
            step = 3'h0;
            return;
        end
        case (step)
            3'h0, 3'h4: step = (u1 && d[7:0] == 8'haa) ? step + 3'h1 : 3'h0;
            3'h1, 3'h5: step = (u2 && d[7:0] == 8'h55) ? step + 3'h1 : 3'h0;
            3'h2: begin
                step = 3'h0;
                if (u1 && d[7:0] == 8'h90) ident = 1'b1;
                if (u1 && d[7:0] == 8'ha0) step = 3'h3;
                if (u1 && d[7:0] == 8'h80) step = 3'h4;
            end
            3'h3: begin
                mt[int'(a)] = $time;
                mem[int'(a)] = rd(int'(a)) & d;
                pd = d;
                busy = 1'b1;
                t_end = $time + 2000;
                step = 3'h0;
            end
            default: begin
                step = 3'h0;
                if (u1 && d[7:0] == 8'h10) begin
                    foreach (et[s]) et[s] = $time;
                    {busy, ers} = 2'b11;
                    t_end = $time + 5000;
                end
                if (d[7:0] == 8'h30) begin
                    sel[a[18:12]] = 1'b1;
                    swin = 1'b1;
                    t_last = $time;
                end
            end
        endcase
    endtask : wr
    // Address at later fall, data at earlier rise
    always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n) begin
        la = addr;
        armed = 1'b1;
    end
    always @(posedge we_n or posedge ce_n) if (armed) begin
        armed = 1'b0;
        wr(la, din);
    end
    // Coarse 500 ns timer, well inside the window
    always #500 begin
        if (swin && $time - t_last >= 80000) begin
            for (int s = 0; s < 128; s++) if (sel[s]) et[s] = $time;
            {swin, busy, ers} = 3'b011;
            t_end = $time + 5000;
        end
        if (busy && $time >= t_end) {busy, ers, sel} = '0;
    end
    always @(addr, ce_n, oe_n, busy, swin, ident) begin
        drive = !ce_n && !oe_n;
        if (busy && !ers) dout = {8'h00, ~pd[7], 7'h00};
        else if (busy) dout = 16'h0008;
        else if (swin) dout = 16'h0000;
        else if (ident && addr[7:0] == 8'h00) dout = MAKER;
        else if (ident && addr[7:0] == 8'h01) dout = DEV;
        else if (ident) dout = {15'h0, PROT[addr[18:12]] && !addr[6]
            && addr[1:0] == 2'b10};
        else dout = rd(int'(addr));
    end
endmodule : nfs_flash

// ---- nfs_host_chk.sv ----
`timescale 1ns/1ps
module nfs_host_chk (
    input wire logic clk, input wire logic reset, // Clock, reset
    input wire logic psel, input wire logic penable, // APB phase
    input wire logic pready, input wire logic pslverr, // APB answer
    input wire logic fl_ce_n, input wire logic fl_we_n, // Strobes
    input wire logic fl_oe_n, input wire logic fl_dq_oe_n, // Strobes
    input wire logic [19:0] fl_addr, // Flash address
    input wire logic [15:0] fl_dq_out // Flash data out
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held");
    ready_wait_a: assert property (psel && penable && !$past(penable)
        |=> pready) else $error("ready late");
    err_ready_a: assert property (pslverr |-> pready && psel && penable)
        else $error("stray error");
    wr_width_a: assert property ($fell(fl_we_n) |=> !fl_we_n ##1 fl_we_n)
        else $error("bad write width");
    wr_pair_a: assert property ($fell(fl_we_n) |-> $fell(fl_ce_n) && fl_oe_n)
        else $error("strobes unpaired");
    wr_hold_a: assert property (!fl_we_n |-> !fl_dq_oe_n && $stable(fl_addr)
        && $stable(fl_dq_out)) else $error("write bus moved");
    wr_tail_a: assert property ($rose(fl_we_n) |-> !fl_dq_oe_n
        && $stable(fl_dq_out)) else $error("data dropped");
    wr_gap_a: assert property ($rose(fl_we_n) |-> fl_we_n [*2])
        else $error("writes too close");
    rd_width_a: assert property ($fell(fl_oe_n) |-> !fl_oe_n [*6] ##1 fl_oe_n)
        else $error("bad read width");
    no_fight_a: assert property (!fl_oe_n |-> fl_dq_oe_n && !fl_ce_n)
        else $error("bus fight");
    cover property (pslverr);
    cover property ($rose(fl_we_n));
    cover property ($rose(fl_oe_n));
endmodule : nfs_host_chk
bind nfs_host nfs_host_chk u_chk (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr),
    .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
    .fl_dq_oe_n(fl_dq_oe_n), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out));

// ---- tb_nfs_host.sv ----
`timescale 1ns/1ps
module tb_nfs_host;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, e, tick;
    logic fl_ce_n, fl_we_n, fl_oe_n, fl_dq_oe_n, f_drv;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [19:0] fl_addr, ka, kb;
    logic [15:0] fl_dq_out, fl_dq_in, f_dq, d, m;
    logic [15:0] sh [int];
    int seed = 77052;
    int fail_count = 0;
    int tests_run = 0;
    nfs_host u_dut (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
        .fl_oe_n(fl_oe_n), .fl_dq_out(fl_dq_out),
        .fl_dq_oe_n(fl_dq_oe_n), .fl_dq_in(fl_dq_in));
    nfs_flash u_flash (.addr(fl_addr), .ce_n(fl_ce_n), .we_n(fl_we_n),
        .oe_n(fl_oe_n), .din(fl_dq_in), .dout(f_dq), .drive(f_drv));
    // Undriven bus churns so stale data never passes
    assign fl_dq_in = !fl_dq_oe_n ? fl_dq_out : f_drv ? f_dq
        : 16'h5aa5 ^ {16{tick}};
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) tick <= ~tick;
    task automatic report_and_stop;
        if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: saw %h want %h", $time, got, exp);
        end
    endtask : check
    // Idle cycle after each transfer
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] wd);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge clk);
    endtask : apb
    task automatic wait_idle;
        do apb(1'b0, 8'h10, 0); while (r[0] !== 1'b0);
    endtask : wait_idle
    task automatic op(input logic [2:0] o, input logic [19:0] a);
        apb(1'b1, 8'h04, {12'h0, a});
        apb(1'b1, 8'h00, {29'h0, o});
        wait_idle();
    endtask : op
    task automatic rdf(input logic [19:0] a);
        op(3'h1, a);
        apb(1'b0, 8'h0c, 0);
    endtask : rdf
    function automatic logic [15:0] exp_rd(input logic [19:0] a);
        return sh.exists(int'(a)) ? sh[int'(a)] : 16'hffff;
    endfunction : exp_rd
    task automatic prog(input logic [19:0] a, input logic [15:0] v);
        apb(1'b1, 8'h08, {16'h0, v});
        op(3'h3, a);
        sh[int'(a)] = exp_rd(a) & v;
        apb(1'b0, 8'h10, 0);
    endtask : prog
    initial begin
        #(40000 * 50);
        fail_count++;
        report_and_stop();
    end
    initial begin
        {reset, pwrite, paddr, pwdata, tick} = '1;
        {psel, penable} = 2'b00;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        // Reset values, then an unmapped place
        for (int i = 1; i < 6; i++) begin
            apb(1'b0, 8'(i * 4), 0);
            check(r, i == 2 ? 32'hffff : 32'h0);
        end
        apb(1'b0, 8'h18, 0);
        check({e, r}, {1'b1, 32'h0});
        rdf(20'($random(seed))); check(r, 32'hffff);
        // Random programs, first in byte mode
        for (int i = 0; i < 4; i++) begin
            ka = 20'($random(seed)) & 20'h7ffff;
            d = 16'($random(seed));
            m = i == 0 ? 16'h00ff : 16'hffff;
            if (i < 2) apb(1'b1, 8'h14, 32'(i == 0));
            prog(ka, d); check(r[2:0], 3'b010);
            rdf(ka); check(r[15:0] & m, exp_rd(ka) & m);
        end
        op(3'h2, 0);
        rdf(0); check(r[15:0], 16'h0007);
        rdf(1); check(r[15:0], 16'h0380);
        rdf(20'h05002); check(r[0], 1'b1);
        rdf(20'h06002); check(r[0], 1'b0);
        rdf(0); check(r[15:0], 16'h0007);
        op(3'h0, 20'h7ffff);
        rdf(ka); check(r[15:0], exp_rd(ka));
        ka = {8'h10, 12'($random(seed))};
        kb = {8'h20, 12'($random(seed))};
        prog(ka, 16'($random(seed)));
        prog(kb, 16'($random(seed)) & 16'hff7f);
        // Launch while busy is refused; append keeps window
        apb(1'b1, 8'h04, {12'h0, ka});
        apb(1'b1, 8'h00, 32'h5);
        apb(1'b1, 8'h00, 32'h0);
        wait_idle(); check(r[5:4], 2'b11);
        op(3'h6, 20'h30000); check(r[5:4], 2'b10);
        rdf(ka); apb(1'b0, 8'h10, 0); check(r[3], 1'b0);
        repeat (1700) @(posedge clk);
        op(3'h7, ka); check(r[2:0], 3'b010);
        rdf(ka); check(r[15:0], 16'hffff);
        rdf(kb); check(r[15:0], exp_rd(kb));
        op(3'h5, kb);
        op(3'h0, 0);
        repeat (1700) @(posedge clk);
        rdf(kb); check(r[15:0], exp_rd(kb));
        op(3'h6, kb); check(r[4], 1'b1);
        op(3'h4, 0); check(r[2:0], 3'b010);
        rdf(kb); check(r[15:0], 16'hffff);
        report_and_stop();
    end
endmodule : tb_nfs_host
